// File: addr_map_pkg.sv
// address map, external bank configuration and bus carriers for the memory controller
package addr_map_pkg;

	// ----------------------------------------------------------------
	// address map
	// ----------------------------------------------------------------
	localparam logic [31:0] EXT_LOW = 32'h0040_0000;
	localparam logic [31:0] EXT_HIGH = 32'hffc0_0000;
	localparam logic [31:0] VECTOR_TOP = 32'h0000_0020;
	localparam logic [31:0] ROM_BASE = 32'h0010_0000;
	localparam logic [31:0] ROM_SIZE = 32'h0002_0000;
	localparam logic [31:0] SRAM_SIZE = 32'h0000_2000;
	localparam logic [31:0] SRAM_BOOT_BASE = 32'h0030_0000;
	localparam logic [31:0] BOOT_ALIAS_TOP = 32'h0010_0000;
	localparam logic [31:0] NO_DATA = 32'h0000_0000;

	// ----------------------------------------------------------------
	// external bus unit
	// ----------------------------------------------------------------
	localparam int EXT_AW = 24;
	localparam int EXT_DW = 16;
	localparam int NUM_BANKS = 8;
	localparam int BANK_IDX_W = 3;
	localparam int BANK_BASE_LSB = 20;
	localparam logic [2:0] SIZE_CODE_MAX = 3'h4;
	localparam int BOOT_SAMPLE_CYCLES = 10;

	typedef enum logic [2:0] {
		RGN_MEM = 3'h1,
		RGN_EXT = 3'h2,
		RGN_PERIPH = 3'h4
	} region_e;

	typedef enum logic [2:0] {
		TGT_NONE = 3'h1,
		TGT_SRAM = 3'h2,
		TGT_ROM = 3'h4
	} mem_tgt_e;

	typedef enum logic [1:0] {
		ACC_BYTE = 2'h0,
		ACC_HALF = 2'h1,
		ACC_WORD = 2'h2
	} acc_size_e;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_SETUP = 4'h2,
		ST_ACCESS = 4'h4,
		ST_FLOAT = 4'h8
	} ext_state_e;

	// size_code: 0 = 1 MB, 1 = 2 MB ... 4 = 16 MB
	typedef struct packed {
		logic enable;
		logic [11:0] base;
		logic [2:0] size_code;
		logic [2:0] wait_states;
		logic [1:0] float_cycles;
		logic width16;
		logic byte_write;
		logic early_read;
	} bank_cfg_s;

	typedef struct packed {
		logic valid;
		logic write;
		acc_size_e size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} core_req_s;

	typedef struct packed {
		logic ready;
		logic abort;
		logic [31:0] rdata;
	} core_rsp_s;

	typedef struct packed {
		logic [NUM_BANKS-1:0] cs_b;
		logic [EXT_AW-1:0] addr;
		logic rd_b;
		logic wr_lo_b;
		logic wr_hi_b;
		logic lb_b;
		logic ub_b;
		logic [EXT_DW-1:0] data;
		logic data_oe_b;
	} ext_pins_s;

	function automatic logic [11:0] bank_mask(input logic [2:0] code);
		logic [2:0] c;
		c = (code > SIZE_CODE_MAX) ? SIZE_CODE_MAX : code;
		return 12'((13'h1 << c) - 13'h1);
	endfunction

	function automatic logic [2:0] beat_count(input acc_size_e size, input logic width16);
		logic [2:0] bytes;
		bytes = 3'(3'h1 << size);
		if (!width16) begin
			return bytes;
		end
		return (bytes == 3'h1) ? 3'h1 : 3'(bytes >> 1);
	endfunction

endpackage

// File: bank_match.sv
// chip-select bank matcher for the external window
module bank_match (
	input wire logic [31:0] addr_i,
	input wire addr_map_pkg::bank_cfg_s [addr_map_pkg::NUM_BANKS-1:0] cfg_i,
	output logic hit_o,
	output logic [addr_map_pkg::BANK_IDX_W-1:0] idx_o
);

	// lowest bank wins when software lets two banks overlap
	always_comb begin
		logic [11:0] mask;
		mask = '0;
		hit_o = 1'b0;
		idx_o = '0;
		for (int i = addr_map_pkg::NUM_BANKS - 1; i >= 0; i--) begin
			mask = addr_map_pkg::bank_mask(cfg_i[i].size_code);
			if (cfg_i[i].enable &&
				((addr_i[31:addr_map_pkg::BANK_BASE_LSB] & ~mask) == (cfg_i[i].base & ~mask))) begin
				hit_o = 1'b1;
				idx_o = addr_map_pkg::BANK_IDX_W'(i);
			end
		end
	end

endmodule

// File: boot_capture.sv
// boot memory strap capture and external reset pin synchroniser
module boot_capture #(
	parameter int SAMPLES = addr_map_pkg::BOOT_SAMPLE_CYCLES,
	parameter logic BOOT_DEFAULT = 1'b1
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic external_reset_pin_b_i,
	input wire logic boot_select_pin_i,
	output logic boot_rom_o,
	output logic ext_reset_active_o
);

	logic rst_meta_ff;
	logic rst_sync_ff;
	logic rst_prev_ff;
	logic sel_meta_ff;
	logic sel_sync_ff;
	logic [SAMPLES-1:0] hist_ff;
	logic boot_rom_ff;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			// idle level of the pin, so leaving reset is not taken as a pin release
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= 1'b1;
			rst_prev_ff <= 1'b1;
			sel_meta_ff <= 1'b0;
			sel_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= external_reset_pin_b_i;
			rst_sync_ff <= rst_meta_ff;
			rst_prev_ff <= rst_sync_ff;
			sel_meta_ff <= boot_select_pin_i;
			sel_sync_ff <= sel_meta_ff;
		end
	end

	// keep the last samples seen while the pin holds reset
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			hist_ff <= '0;
		end else if (!rst_sync_ff) begin
			hist_ff <= {hist_ff[SAMPLES-2:0], sel_sync_ff};
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			boot_rom_ff <= BOOT_DEFAULT;
		end else if (rst_sync_ff && !rst_prev_ff) begin
			// a level that moved inside the window falls back to the newest sample
			if (&hist_ff) begin
				boot_rom_ff <= 1'b1;
			end else if (~|hist_ff) begin
				boot_rom_ff <= 1'b0;
			end else begin
				boot_rom_ff <= hist_ff[0];
			end
		end
	end

	assign boot_rom_o = boot_rom_ff;
	assign ext_reset_active_o = !rst_sync_ff;

endmodule

// File: addr_decode_remap.sv
// memory controller address decoder with vector remap, abort and external bus unit
module addr_decode_remap (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic external_reset_pin_b_i,
	input wire logic boot_select_pin_i,
	input wire logic remap_command_bit_i,
	input wire addr_map_pkg::bank_cfg_s [addr_map_pkg::NUM_BANKS-1:0] bank_cfg_i,
	input wire addr_map_pkg::core_req_s core_req_i,
	output addr_map_pkg::core_rsp_s core_rsp_o,
	input wire logic int_ready_i,
	input wire logic [31:0] int_rdata_i,
	output addr_map_pkg::region_e region_o,
	output addr_map_pkg::mem_tgt_e mem_target_o,
	output logic periph_sel_o,
	output logic [31:0] local_addr_o,
	input wire logic [addr_map_pkg::EXT_DW-1:0] ext_data_i,
	output addr_map_pkg::ext_pins_s ext_pins_o,
	output logic remap_done_o,
	output logic boot_rom_o
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	addr_map_pkg::region_e region;
	addr_map_pkg::mem_tgt_e mem_tgt;
	addr_map_pkg::ext_state_e state_ff;
	addr_map_pkg::bank_cfg_s cfg_ff;
	addr_map_pkg::bank_cfg_s sel_cfg;
	addr_map_pkg::acc_size_e size_ff;
	logic [31:0] local_addr;
	logic boot_ext;
	logic boot_rom;
	logic ext_reset_active;
	logic remap_ff;
	logic bank_hit;
	logic [addr_map_pkg::BANK_IDX_W-1:0] hit_idx;
	logic [addr_map_pkg::BANK_IDX_W-1:0] sel_idx;
	logic [addr_map_pkg::BANK_IDX_W-1:0] bank_ff;
	logic ext_go;
	logic abort;
	logic start;
	logic beat_end;
	logic last_beat;
	logic done_ff;
	logic write_ff;
	logic [addr_map_pkg::EXT_AW-1:0] addr_ff;
	logic [31:0] wdata_ff;
	logic [31:0] rdata_ff;
	logic [2:0] beats_left_ff;
	logic [2:0] wait_cnt_ff;
	logic [1:0] float_cnt_ff;
	logic lo_used;
	logic hi_used;
	logic [7:0] wbyte;

	boot_capture u_boot (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.external_reset_pin_b_i(external_reset_pin_b_i),
		.boot_select_pin_i(boot_select_pin_i),
		.boot_rom_o(boot_rom),
		.ext_reset_active_o(ext_reset_active)
	);

	bank_match u_match (
		.addr_i(core_req_i.addr),
		.cfg_i(bank_cfg_i),
		.hit_o(bank_hit),
		.idx_o(hit_idx)
	);

	// ----------------------------------------------------------------
	// remap state
	// ----------------------------------------------------------------
	// only a reset undoes remap
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i || ext_reset_active) begin
			remap_ff <= 1'b0;
		end else if (remap_command_bit_i) begin
			remap_ff <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// region and target decode
	// ----------------------------------------------------------------
	// three-way region split
	always_comb begin
		region = addr_map_pkg::RGN_MEM;
		if (core_req_i.addr >= addr_map_pkg::EXT_HIGH) begin
			region = addr_map_pkg::RGN_PERIPH;
		end else if (core_req_i.addr >= addr_map_pkg::EXT_LOW) begin
			region = addr_map_pkg::RGN_EXT;
		end
	end

	always_comb begin
		mem_tgt = addr_map_pkg::TGT_NONE;
		local_addr = core_req_i.addr;
		boot_ext = 1'b0;
		if (region == addr_map_pkg::RGN_MEM) begin
			if (remap_ff && core_req_i.addr < addr_map_pkg::SRAM_SIZE) begin
				mem_tgt = addr_map_pkg::TGT_SRAM;
			end else if (!remap_ff && core_req_i.addr < addr_map_pkg::BOOT_ALIAS_TOP) begin
				if (!boot_rom) begin
					boot_ext = 1'b1;
				end else if (core_req_i.addr < addr_map_pkg::ROM_SIZE) begin
					mem_tgt = addr_map_pkg::TGT_ROM;
				end
			end else if (core_req_i.addr >= addr_map_pkg::ROM_BASE &&
				core_req_i.addr < addr_map_pkg::ROM_BASE + addr_map_pkg::ROM_SIZE) begin
				mem_tgt = addr_map_pkg::TGT_ROM;
				local_addr = core_req_i.addr - addr_map_pkg::ROM_BASE;
			end else if (!remap_ff && core_req_i.addr >= addr_map_pkg::SRAM_BOOT_BASE &&
				core_req_i.addr < addr_map_pkg::SRAM_BOOT_BASE + addr_map_pkg::SRAM_SIZE) begin
				mem_tgt = addr_map_pkg::TGT_SRAM;
				local_addr = core_req_i.addr - addr_map_pkg::SRAM_BOOT_BASE;
			end
		end
	end

	// external boot goes to bank 0 regardless of its programmed base
	assign sel_idx = boot_ext ? '0 : hit_idx;
	assign sel_cfg = bank_cfg_i[sel_idx];
	assign ext_go = core_req_i.valid && ((region == addr_map_pkg::RGN_EXT && bank_hit) || boot_ext);
	assign abort = core_req_i.valid && region == addr_map_pkg::RGN_EXT && !bank_hit;
	assign start = ext_go && state_ff == addr_map_pkg::ST_IDLE && !done_ff;

	assign region_o = region;
	assign mem_target_o = core_req_i.valid ? mem_tgt : addr_map_pkg::TGT_NONE;
	assign periph_sel_o = core_req_i.valid && region == addr_map_pkg::RGN_PERIPH;
	assign local_addr_o = local_addr;
	assign remap_done_o = remap_ff;
	assign boot_rom_o = boot_rom;

	// ----------------------------------------------------------------
	// core answer
	// ----------------------------------------------------------------
	always_comb begin
		core_rsp_o.abort = abort;
		core_rsp_o.ready = 1'b0;
		core_rsp_o.rdata = rdata_ff;
		if (abort) begin
			core_rsp_o.ready = 1'b1;
		end else if (ext_go) begin
			core_rsp_o.ready = done_ff;
		end else if (core_req_i.valid) begin
			if (region == addr_map_pkg::RGN_MEM && mem_tgt == addr_map_pkg::TGT_NONE) begin
				core_rsp_o.ready = 1'b1;
				core_rsp_o.rdata = addr_map_pkg::NO_DATA;
			end else begin
				core_rsp_o.ready = int_ready_i;
				core_rsp_o.rdata = int_rdata_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// external access sequencer
	// ----------------------------------------------------------------
	assign beat_end = state_ff == addr_map_pkg::ST_ACCESS && wait_cnt_ff == 3'h0;
	assign last_beat = beats_left_ff == 3'h1;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			state_ff <= addr_map_pkg::ST_IDLE;
			cfg_ff <= '0;
			bank_ff <= '0;
			addr_ff <= '0;
			write_ff <= 1'b0;
			size_ff <= addr_map_pkg::ACC_BYTE;
			wdata_ff <= '0;
			beats_left_ff <= '0;
			wait_cnt_ff <= '0;
			float_cnt_ff <= '0;
		end else begin
			case (state_ff)
				addr_map_pkg::ST_IDLE: begin
					if (start) begin
						cfg_ff <= sel_cfg;
						bank_ff <= sel_idx;
						addr_ff <= core_req_i.addr[addr_map_pkg::EXT_AW-1:0];
						write_ff <= core_req_i.write;
						size_ff <= core_req_i.size;
						wdata_ff <= core_req_i.wdata;
						beats_left_ff <= addr_map_pkg::beat_count(core_req_i.size, sel_cfg.width16);
						wait_cnt_ff <= sel_cfg.wait_states;
						// early read adds a leading strobe cycle
						state_ff <= (sel_cfg.early_read && !core_req_i.write) ?
							addr_map_pkg::ST_SETUP : addr_map_pkg::ST_ACCESS;
					end
				end
				addr_map_pkg::ST_SETUP: begin
					state_ff <= addr_map_pkg::ST_ACCESS;
				end
				addr_map_pkg::ST_ACCESS: begin
					if (wait_cnt_ff != 3'h0) begin
						wait_cnt_ff <= wait_cnt_ff - 3'h1;
					end else if (last_beat) begin
						// float time before the next access
						float_cnt_ff <= cfg_ff.float_cycles;
						state_ff <= (cfg_ff.float_cycles != 2'h0) ?
							addr_map_pkg::ST_FLOAT : addr_map_pkg::ST_IDLE;
					end else begin
						beats_left_ff <= beats_left_ff - 3'h1;
						addr_ff <= addr_ff + (cfg_ff.width16 ? 24'h00_0002 : 24'h00_0001);
						wait_cnt_ff <= cfg_ff.wait_states;
						state_ff <= (cfg_ff.early_read && !write_ff) ?
							addr_map_pkg::ST_SETUP : addr_map_pkg::ST_ACCESS;
					end
				end
				addr_map_pkg::ST_FLOAT: begin
					float_cnt_ff <= float_cnt_ff - 2'h1;
					if (float_cnt_ff == 2'h1) begin
						state_ff <= addr_map_pkg::ST_IDLE;
					end
				end
				default: begin
					state_ff <= addr_map_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// one-cycle completion; it also blocks a restart of the same request
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			done_ff <= 1'b0;
		end else begin
			done_ff <= beat_end && last_beat;
		end
	end

	// read bytes land in their own lanes
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			rdata_ff <= '0;
		end else if (start) begin
			rdata_ff <= '0;
		end else if (beat_end && !write_ff) begin
			for (int j = 0; j < 4; j++) begin
				if (cfg_ff.width16) begin
					if (j[1] == addr_ff[1] &&
						(size_ff != addr_map_pkg::ACC_BYTE || j[0] == addr_ff[0])) begin
						rdata_ff[8*j +: 8] <= ext_data_i[8*j[0] +: 8];
					end
				end else if (j[1:0] == addr_ff[1:0]) begin
					rdata_ff[8*j +: 8] <= ext_data_i[7:0];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// external pins, decoded from registered state
	// ----------------------------------------------------------------
	assign wbyte = wdata_ff[{addr_ff[1:0], 3'h0} +: 8];
	assign lo_used = !cfg_ff.width16 || size_ff != addr_map_pkg::ACC_BYTE || !addr_ff[0];
	assign hi_used = cfg_ff.width16 && (size_ff != addr_map_pkg::ACC_BYTE || addr_ff[0]);

	always_comb begin
		ext_pins_o.cs_b = '1;
		ext_pins_o.addr = addr_ff;
		ext_pins_o.rd_b = 1'b1;
		ext_pins_o.wr_lo_b = 1'b1;
		ext_pins_o.wr_hi_b = 1'b1;
		ext_pins_o.lb_b = 1'b1;
		ext_pins_o.ub_b = 1'b1;
		ext_pins_o.data_oe_b = 1'b1;
		if (cfg_ff.width16 && size_ff != addr_map_pkg::ACC_BYTE) begin
			ext_pins_o.data = wdata_ff[{addr_ff[1], 4'h0} +: 16];
		end else begin
			ext_pins_o.data = cfg_ff.width16 ? {wbyte, wbyte} : {8'h00, wbyte};
		end
		if (state_ff == addr_map_pkg::ST_SETUP || state_ff == addr_map_pkg::ST_ACCESS) begin
			ext_pins_o.cs_b[bank_ff] = 1'b0;
			// byte-select lanes for one wide device
			if (cfg_ff.width16 && !cfg_ff.byte_write) begin
				ext_pins_o.lb_b = !lo_used;
				ext_pins_o.ub_b = !hi_used;
			end
			if (write_ff) begin
				ext_pins_o.data_oe_b = 1'b0;
				// byte-write strobes for two narrow devices
				if (cfg_ff.width16 && cfg_ff.byte_write) begin
					ext_pins_o.wr_lo_b = !lo_used;
					ext_pins_o.wr_hi_b = !hi_used;
				end else begin
					ext_pins_o.wr_lo_b = 1'b0;
				end
			end else begin
				ext_pins_o.rd_b = 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	AST_ONE_REGION: assert property (
		core_req_i.valid |-> $onehot({region_o == addr_map_pkg::RGN_MEM,
			region_o == addr_map_pkg::RGN_EXT, region_o == addr_map_pkg::RGN_PERIPH}))
		else $error("address not in exactly one region");

	AST_PERIPH_TOP: assert property (
		core_req_i.valid && core_req_i.addr >= 32'hffc0_0000 |-> periph_sel_o && !core_rsp_o.abort)
		else $error("top address not routed to peripherals");

	AST_MEM_BOTTOM: assert property (
		core_req_i.valid && core_req_i.addr < 32'h0040_0000 |->
			region_o == addr_map_pkg::RGN_MEM && !periph_sel_o)
		else $error("bottom address not routed to memories");

	AST_VECTOR_SRAM: assert property (
		core_req_i.valid && remap_done_o && core_req_i.addr <= 32'h0000_0020 |->
			mem_target_o == addr_map_pkg::TGT_SRAM && local_addr_o == core_req_i.addr)
		else $error("vector area not in SRAM after remap");

	AST_REMAP_SET: assert property (
		remap_command_bit_i && !ext_reset_active |=> remap_done_o)
		else $error("remap command ignored");

	AST_REMAP_HOLD: assert property (
		remap_done_o && !ext_reset_active |=> remap_done_o)
		else $error("remap undone without reset");

	AST_ABORT_NOW: assert property (
		core_req_i.valid && region_o == addr_map_pkg::RGN_EXT && !bank_hit |->
			core_rsp_o.abort && core_rsp_o.ready && !start)
		else $error("abort late or external cycle started");

	AST_NO_ABORT_INT: assert property (
		region_o != addr_map_pkg::RGN_EXT |-> !core_rsp_o.abort)
		else $error("abort outside external window");

	AST_WAIT_STRETCH: assert property (
		state_ff == addr_map_pkg::ST_ACCESS && wait_cnt_ff != 3'h0 |=>
			state_ff == addr_map_pkg::ST_ACCESS && wait_cnt_ff == $past(wait_cnt_ff) - 3'h1)
		else $error("wait state skipped");

	AST_FLOAT_IDLE: assert property (
		state_ff == addr_map_pkg::ST_FLOAT |-> ext_pins_o.cs_b == '1 && ext_pins_o.data_oe_b
			&& !start)
		else $error("bus driven during float time");

	AST_ROM_BASE: assert property (
		core_req_i.valid && core_req_i.addr == 32'h0010_0000 |->
			mem_target_o == addr_map_pkg::TGT_ROM && local_addr_o == 32'h0)
		else $error("ROM base not decoded");

	COV_REMAP: cover property (remap_command_bit_i ##1 remap_done_o);
	COV_ABORT: cover property (core_rsp_o.abort);
	COV_EXT_DONE: cover property (state_ff == addr_map_pkg::ST_ACCESS ##[1:20] done_ff);
	COV_FLOAT: cover property (state_ff == addr_map_pkg::ST_FLOAT);

endmodule

// File: ext_mem_model.sv
// external memory model that answers the chip-select bus
module ext_mem_model (
	input wire logic ref_clk_i,
	input wire addr_map_pkg::ext_pins_s pins_i,
	output logic [15:0] data_o,
	output int wr_cycles_o,
	output logic [15:0] wr_data_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// read data and write capture
	// ----------------------------------------------------------------
	logic [15:0] last_ff;
	logic sel;
	logic wsel;
	assign sel = (~&pins_i.cs_b) & ~pins_i.rd_b;
	assign wsel = (~&pins_i.cs_b) & ~pins_i.data_oe_b & ~(pins_i.wr_lo_b & pins_i.wr_hi_b);
	// a released bus shows the inverse of the last value, so stale data never matches
	assign data_o = sel ? {pins_i.addr[7:0] ^ 8'h3c, pins_i.addr[7:0]} : ~last_ff;
	// count strobe cycles and keep the newest data a device would latch
	always @(posedge ref_clk_i) begin
		last_ff <= data_o;
		if (wsel) begin
			wr_cycles_o <= wr_cycles_o + 1;
			wr_data_o <= pins_i.data;
		end
	end
endmodule

// File: address_decode_remap_abort_bench.sv
// self-checking bench for the decoder, vector remap, abort and external bus unit
module address_decode_remap_abort_bench;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// signals and design
	// ----------------------------------------------------------------
	logic ref_clk_i = 1'b0, rst_b_i = 1'b0, pin_b = 1'b1, boot_sel = 1'b1, remap_cmd = 1'b0;
	addr_map_pkg::bank_cfg_s [7:0] cfg = '0;
	addr_map_pkg::core_req_s req = '0;
	addr_map_pkg::core_rsp_s rsp;
	addr_map_pkg::region_e region, reg_s;
	addr_map_pkg::mem_tgt_e tgt, tgt_s;
	addr_map_pkg::ext_pins_s pins;
	logic psel, psel_s, done, brom, got_ab;
	logic [31:0] laddr, loc_s, got_d, a, rdata_i = 32'h0;
	logic [15:0] xdata, wr_dat;
	logic [31:0] corner [5] = '{32'h003f_fffc, 32'h0040_0000, 32'hffbf_fffc, 32'hffc0_0000,
		32'hffff_fffc};
	int fails = 0, comparisons = 0, n, beats, wc, wr_cyc;

	addr_decode_remap uut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.external_reset_pin_b_i(pin_b), .boot_select_pin_i(boot_sel),
		.remap_command_bit_i(remap_cmd), .bank_cfg_i(cfg), .core_req_i(req),
		.core_rsp_o(rsp), .int_ready_i(1'b1), .int_rdata_i(rdata_i), .region_o(region),
		.mem_target_o(tgt), .periph_sel_o(psel), .local_addr_o(laddr), .ext_data_i(xdata),
		.ext_pins_o(pins), .remap_done_o(done), .boot_rom_o(brom));
	ext_mem_model mem_model (.ref_clk_i(ref_clk_i), .pins_i(pins), .data_o(xdata),
		.wr_cycles_o(wr_cyc), .wr_data_o(wr_dat));

	initial forever #5 ref_clk_i = ~ref_clk_i;
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic addr_map_pkg::region_e exp_region(input logic [31:0] x);
		if (x >= addr_map_pkg::EXT_HIGH) return addr_map_pkg::RGN_PERIPH;
		if (x < addr_map_pkg::EXT_LOW) return addr_map_pkg::RGN_MEM;
		return addr_map_pkg::RGN_EXT;
	endfunction
	// word read data as the model serves it, low lane first
	function automatic logic [31:0] exp_word(input logic [7:0] x, input logic w16);
		if (w16) return {(x + 8'h2) ^ 8'h3c, x + 8'h2, x ^ 8'h3c, x};
		return {x + 8'h3, x + 8'h2, x + 8'h1, x};
	endfunction
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_n(input string what, input int exp, input int got);
		comparisons++;
		if (got != exp) begin
			fails++;
			$display("unexpected %s: expected %0d seen %0d", what, exp, got);
		end
	endtask
	// word access held until ready, released the cycle after
	task automatic access(input logic [31:0] adr, input logic wr);
		@(negedge ref_clk_i);
		req.valid = 1'b1;
		req.write = wr;
		req.size = addr_map_pkg::ACC_WORD;
		req.addr = adr;
		req.wdata = $urandom();
		rdata_i = $urandom();
		n = 0;
		#1;
		reg_s = region;
		tgt_s = tgt;
		loc_s = laddr;
		psel_s = psel;
		while (rsp.ready !== 1'b1 && n < 200) begin
			@(negedge ref_clk_i);
			#1;
			n++;
		end
		got_d = rsp.rdata;
		got_ab = rsp.abort;
		@(negedge ref_clk_i);
		req.valid = 1'b0;
	endtask
	task automatic pin_reset(input logic strap);
		boot_sel = strap;
		pin_b = 1'b0;
		repeat (15) @(negedge ref_clk_i);
		pin_b = 1'b1;
		repeat (5) @(negedge ref_clk_i);
		check("remap after pin reset", 32'h0, {31'h0, done});
		check("boot strap", {31'h0, strap}, {31'h0, brom});
	endtask
	task automatic complete_run();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		#200000;
		fails++;
		complete_run();
	end
	initial begin
		void'($urandom(32'hb636d2a0));
		repeat (16) @(negedge ref_clk_i);
		rst_b_i = 1'b1;
		repeat (3) @(negedge ref_clk_i);
		for (int i = 0; i < 45; i++) begin
			a = (i < 5) ? corner[i] : ($urandom() & 32'hffff_fffc);
			access(a, i[0]);
			check("region", 32'(exp_region(a)), 32'(reg_s));
			check("abort", {31'h0, exp_region(a) == addr_map_pkg::RGN_EXT}, {31'h0, got_ab});
			check("periph select", {31'h0, a >= addr_map_pkg::EXT_HIGH}, {31'h0, psel_s});
			check_n("answer cycles", 0, n);
		end
		$display("test decode done");
		access(32'h0010_0040, 1'b0);
		check("rom target", 32'h4, 32'(tgt_s));
		check("rom offset", 32'h40, loc_s);
		check("internal read data", rdata_i, got_d);
		access(32'h0000_0010, 1'b0);
		check("boot vector target", 32'h4, 32'(tgt_s));
		// software remaps before touching chip selects one to seven
		remap_cmd = 1'b1;
		@(negedge ref_clk_i);
		remap_cmd = 1'b0;
		check("remap done", 32'h1, {31'h0, done});
		repeat (20) @(negedge ref_clk_i);
		access(32'h0000_0010, 1'b0);
		check("remapped target", 32'h2, 32'(tgt_s));
		check("remapped offset", 32'h10, loc_s);
		check("remap persists", 32'h1, {31'h0, done});
		$display("test remap done");
		for (int i = 0; i < 10; i++) begin
			cfg[1] = '0;
			cfg[1].enable = 1'b1;
			cfg[1].base = 12'h010;
			cfg[1].size_code = 3'($urandom_range(4, 0));
			cfg[1].wait_states = 3'($urandom());
			cfg[1].float_cycles = 2'($urandom());
			cfg[1].width16 = i[0];
			cfg[1].byte_write = i[1];
			cfg[1].early_read = i[2];
			a = 32'h0100_0000 + ($urandom() & ((32'h1 << (20 + cfg[1].size_code)) - 32'h4));
			beats = cfg[1].width16 ? 2 : 4;
			access(a, 1'b0);
			check("ext read", exp_word(a[7:0], cfg[1].width16), got_d);
			check_n("ext cycles", beats * (1 + cfg[1].wait_states + cfg[1].early_read) + 1,
				n);
			check("ext abort", 32'h0, {31'h0, got_ab});
			access(32'h0100_0000 + (32'h1 << (20 + cfg[1].size_code)), 1'b0);
			check("past bank abort", 32'h1, {31'h0, got_ab});
			wc = wr_cyc;
			access(a, 1'b1);
			check_n("write cycles", beats * (1 + cfg[1].wait_states) + 1, n);
			check_n("write strobe cycles", beats * (1 + cfg[1].wait_states), wr_cyc - wc);
			check("last write lanes", cfg[1].width16 ? {16'h0, req.wdata[31:16]} :
				{24'h0, req.wdata[31:24]}, {16'h0, wr_dat});
			// let the float time run out before the bank is programmed again
			repeat (4) @(negedge ref_clk_i);
		end
		$display("test external done");
		pin_reset(1'b0);
		pin_reset(1'b1);
		$display("test pin reset done");
		complete_run();
	end
endmodule
